// >>> hw/ssilp_top.sv
/*
  System integration unit: pending-status views, reset causes, break
  steering with flag protection, and wait/stop sequencing.
  Assumes the CPU bus, break module and peripherals share clk_sys and that
  the 4x bus clock enable tick is supplied synchronous to clk_sys.
*/
// Function
// - pending_status_a shows flags one to six; bits one and zero read zero.
// - pending_status_b holds flags seven-fourteen, pending_status_c fifteen-twenty-two.
// - All reset sources share top priority above interrupts, no arbitration.
// - Break request forces software-interrupt vector fetch, entering break state.
// - In break, foreign flag clears blocked unless break_flag_clear_enable is one.
// - Flags cleared during break stay cleared after break ends.
// - Two-step clears stay protected in break; second step afterwards clears normally.
// - Wait or stop clears the global interrupt mask and stops CPU clock.
// - Wait stops CPU clocks only; peripheral clocks keep running.
// - Wait wakeup: stacking starts two cycles after interrupt arrives.
// - Reset, or break with emulation_mode set, ends wait; break in wait sets break_in_stop_wait_flag.
// - With watchdog_disable zero, the watchdog runs during wait.
// - Stop resets system counter, gates bus_clock_double, and gates bus_clock_quad unless oscillator_in_stop_enable; interrupt, reset, break exit.
// - oscillator_in_stop_enable keeps bus_clock_quad running during stop.
// - Stop recovery is 4096 quad cycles, or 32 with short recovery set.
// - Counter held reset until recovery, then times it; stacking after it elapses.
// - Reading reset_cause clears it automatically.
// - Power-on sets its bit and clears others; other sources only accumulate.
// - Pin, watchdog, bad opcode, bad fetch and low-voltage each set own bit.
// - Monitor entry after power-on with blank reset vector sets monitor_entry_flag.
// - Decode break status FE00, reset cause FE01, break flag control FE03.
// - Each pending flag maps to one maskable interrupt source.
`timescale 1ns/1ns
`default_nettype none
module ssilp_top #(
  parameter int          NUM_FLAGS = 22,
  parameter logic [12:0] REC_LONG  = ssilp_pkg::REC_LONG_CYC
) (
  // Clock and reset
  input  wire logic                      clk_sys,
  input  wire logic                      rst_n,
  // Reset sources
  input  wire logic                      por_event,
  input  wire ssilp_pkg::ssilp_rst_src_t rst_src,
  // CPU register bus
  input  wire ssilp_pkg::ssilp_bus_t     bus_in,
  output var  logic [7:0]                bus_rdata,
  // Interrupt and break inputs
  input  wire logic [NUM_FLAGS:1]        irq_pending,
  input  wire logic                      break_req,
  input  wire logic                      emulation_mode,
  // CPU instruction events
  input  wire logic                      wait_exec,
  input  wire logic                      stop_exec,
  // Configuration
  input  wire logic                      watchdog_disable,
  input  wire logic                      short_recovery_select,
  input  wire logic                      oscillator_in_stop_enable,
  input  wire logic                      quad_tick,
  // Controls to CPU and peripherals
  output var  logic                      cpu_reset,
  output var  logic                      force_swi_vector,
  output var  logic                      clear_imask,
  output var  logic                      start_stacking,
  output var  logic                      cpu_clk_en,
  output var  logic                      bus_clock_double,
  output var  logic                      bus_clock_quad,
  output var  logic                      watchdog_run,
  output var  logic                      flag_clear_allow,
  output var  logic                      break_active
);
  import ssilp_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  ssilp_state_t st_q, st_d;
  logic [12:0]  cnt_q, cnt_d;
  logic [7:0]   cause_q, cause_d;
  logic [7:0]   bstat_q, bstat_d;
  logic [7:0]   bfc_q, bfc_d;
  logic [7:0]   rdata_d;
  logic         brk_q, brk_d;
  logic         any_irq, any_rst, wake;
  logic         rst_q, swi_q, imask_q, stack_q, cpuen_q, dbl_q, quad_q;
  logic         wdog_q, allow_q;
  logic         rst_d, swi_d, imask_d, stack_d, cpuen_d, dbl_d, quad_d;
  logic         wdog_d, allow_d;
  logic [12:0]  rec_len;
  logic         rd_cause, wr_bfc, wr_bstat, brk_in_lp;
  logic [7:0]   pend_a, pend_b, pend_c;

  assign any_irq = |irq_pending;
  assign any_rst = por_event | (|rst_src);
  assign wake    = any_irq | any_rst | break_req;
  assign rec_len = short_recovery_select ? REC_SHORT_CYC : REC_LONG;

  // ----------------------------------------------------------------------
  // Register read path
  // ----------------------------------------------------------------------
  assign rd_cause  = bus_in.rd && (bus_in.addr == ADDR_RESET_CAUSE);
  assign wr_bfc    = bus_in.wr && (bus_in.addr == ADDR_BREAK_FLAG_CTL);
  assign wr_bstat  = bus_in.wr && (bus_in.addr == ADDR_BREAK_STATUS);
  assign brk_in_lp = (st_q == SSILP_WAIT || st_q == SSILP_STOP) && break_req;
  assign pend_a    = {irq_pending[6:1], 2'b00};
  assign pend_b    = irq_pending[14:7];
  assign pend_c    = irq_pending[22:15];

  always_comb begin
    rdata_d = 8'h00;
    unique case (bus_in.addr)
      ADDR_BREAK_STATUS: begin
        rdata_d = bstat_q;
      end
      ADDR_RESET_CAUSE: begin
        rdata_d = cause_q;
      end
      ADDR_BREAK_FLAG_CTL: begin
        rdata_d = bfc_q;
      end
      ADDR_PEND_A: begin
        rdata_d = pend_a;
      end
      ADDR_PEND_B: begin
        rdata_d = pend_b;
      end
      ADDR_PEND_C: begin
        rdata_d = pend_c;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bus_rdata <= 8'h00;
    end else begin
      bus_rdata <= rdata_d;
    end
  end

  // ----------------------------------------------------------------------
  // Reset cause
  // ----------------------------------------------------------------------
  always_comb begin
    cause_d = cause_q;
    if (rd_cause) begin
      cause_d = 8'h00;
    end
    // New causes win over a clearing read
    if (por_event) begin
      cause_d         = 8'h00;
      cause_d[RC_POR] = 1'b1;
      cause_d[RC_MON] = rst_src.monitor;
    end else begin
      if (rst_src.pin) begin
        cause_d[RC_PIN] = 1'b1;
      end
      if (rst_src.wdog) begin
        cause_d[RC_WDOG] = 1'b1;
      end
      if (rst_src.bad_opcode) begin
        cause_d[RC_BADOP] = 1'b1;
      end
      if (rst_src.bad_fetch) begin
        cause_d[RC_BADAD] = 1'b1;
      end
      if (rst_src.low_voltage) begin
        cause_d[RC_LVI] = 1'b1;
      end
      if (rst_src.monitor) begin
        cause_d[RC_MON] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cause_q <= 8'h00;
    end else begin
      cause_q <= cause_d;
    end
  end

  // ----------------------------------------------------------------------
  // Break status and flag control
  // ----------------------------------------------------------------------
  always_comb begin
    bstat_d = bstat_q;
    bfc_d   = bfc_q;
    if (wr_bfc) begin
      bfc_d = {bus_in.wdata[BF_BREAK_FLAG_CLEAR_ENABLE], 7'h00};
    end
    if (wr_bstat && !bus_in.wdata[BS_BREAK_IN_STOP_WAIT_FLAG]) begin
      bstat_d[BS_BREAK_IN_STOP_WAIT_FLAG] = 1'b0;
    end
    // Set wins over a clearing write
    if (brk_in_lp) begin
      bstat_d[BS_BREAK_IN_STOP_WAIT_FLAG] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bstat_q <= RST_BREAK_STATUS;
      bfc_q   <= RST_BREAK_FLAG_CTL;
    end else begin
      bstat_q <= bstat_d;
      bfc_q   <= bfc_d;
    end
  end

  // ----------------------------------------------------------------------
  // Low-power sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    imask_d = 1'b0;
    stack_d = 1'b0;
    cpuen_d = 1'b1;
    dbl_d   = 1'b1;
    quad_d  = 1'b1;
    if (any_rst) begin
      st_d = SSILP_RUN;
    end else begin
      unique case (st_q)
        SSILP_RUN: begin
          if (wait_exec) begin
            st_d    = SSILP_WAIT;
            imask_d = 1'b1;
            cpuen_d = 1'b0;
          end else if (stop_exec) begin
            st_d    = SSILP_STOP;
            imask_d = 1'b1;
            cpuen_d = 1'b0;
            cnt_d   = 13'h0000;
            dbl_d   = 1'b0;
            quad_d  = oscillator_in_stop_enable;
          end
        end
        SSILP_WAIT: begin
          cpuen_d = 1'b0;
          if (any_irq) begin
            st_d = SSILP_WAIT_EXIT;
          end else if (break_req && emulation_mode) begin
            st_d    = SSILP_RUN;
            cpuen_d = 1'b1;
          end
        end
        SSILP_WAIT_EXIT: begin
          st_d    = SSILP_RUN;
          stack_d = 1'b1;
        end
        SSILP_STOP: begin
          cpuen_d = 1'b0;
          dbl_d   = 1'b0;
          quad_d  = oscillator_in_stop_enable;
          cnt_d   = 13'h0000;
          if (any_irq || break_req) begin
            st_d = SSILP_RECOVER;
          end
        end
        SSILP_RECOVER: begin
          cpuen_d = 1'b0;
          dbl_d   = 1'b0;
          if (quad_tick) begin
            cnt_d = cnt_q + 13'h0001;
          end
          if (cnt_q >= rec_len) begin
            st_d    = SSILP_RUN;
            stack_d = any_irq;
            cpuen_d = 1'b1;
            dbl_d   = 1'b1;
          end
        end
        default: st_d = SSILP_RUN;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q    <= SSILP_RUN;
      cnt_q   <= 13'h0000;
      imask_q <= 1'b0;
      stack_q <= 1'b0;
      cpuen_q <= 1'b1;
      dbl_q   <= 1'b1;
      quad_q  <= 1'b1;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      imask_q <= imask_d;
      stack_q <= stack_d;
      cpuen_q <= cpuen_d;
      dbl_q   <= dbl_d;
      quad_q  <= quad_d;
    end
  end

  // ----------------------------------------------------------------------
  // Break tracking
  // ----------------------------------------------------------------------
  always_comb begin
    brk_d = brk_q;
    swi_d = 1'b0;
    if (any_rst) begin
      brk_d = 1'b0;
    end else if (break_req && !brk_q) begin
      swi_d = 1'b1;
      brk_d = 1'b1;
    end else if (!break_req) begin
      brk_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      brk_q <= 1'b0;
      swi_q <= 1'b0;
    end else begin
      brk_q <= brk_d;
      swi_q <= swi_d;
    end
  end

  // ----------------------------------------------------------------------
  // Reset, watchdog and flag-clear controls
  // ----------------------------------------------------------------------
  always_comb begin
    rst_d   = any_rst;
    wdog_d  = !watchdog_disable && (st_d != SSILP_STOP);
    allow_d = !brk_d || bfc_q[BF_BREAK_FLAG_CLEAR_ENABLE];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rst_q   <= 1'b1;
      wdog_q  <= 1'b0;
      allow_q <= 1'b1;
    end else begin
      rst_q   <= rst_d;
      wdog_q  <= wdog_d;
      allow_q <= allow_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------

  assign cpu_reset        = rst_q;
  assign force_swi_vector = swi_q;
  assign clear_imask      = imask_q;
  assign start_stacking   = stack_q;
  assign cpu_clk_en       = cpuen_q;
  assign bus_clock_double = dbl_q;
  assign bus_clock_quad   = quad_q;
  assign watchdog_run     = wdog_q;
  assign flag_clear_allow = allow_q;
  assign break_active     = brk_q;

endmodule // ssilp_top
`default_nettype wire

// >>> hw/ssilp_pkg.sv
/*
  Package for the system integration and low-power sequencer block.
  Assumes one synchronous clock domain; addresses are 16-bit CPU addresses.
*/
package ssilp_pkg;

  // ----------------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------------
  localparam logic [15:0] ADDR_BREAK_STATUS   = 16'hFE00;
  localparam logic [15:0] ADDR_RESET_CAUSE    = 16'hFE01;
  localparam logic [15:0] ADDR_BREAK_FLAG_CTL = 16'hFE03;
  localparam logic [15:0] ADDR_PEND_A         = 16'hFE04;
  localparam logic [15:0] ADDR_PEND_B         = 16'hFE05;
  localparam logic [15:0] ADDR_PEND_C         = 16'hFE06;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int RC_POR   = 7;
  localparam int RC_PIN   = 6;
  localparam int RC_WDOG  = 5;
  localparam int RC_BADOP = 4;
  localparam int RC_BADAD = 3;
  localparam int RC_MON   = 1;
  localparam int RC_LVI   = 0;
  localparam int BS_BREAK_IN_STOP_WAIT_FLAG  = 1;
  localparam int BF_BREAK_FLAG_CLEAR_ENABLE  = 7;

  // ----------------------------------------------------------------------
  // Reset values and timing counts
  // ----------------------------------------------------------------------
  localparam logic [7:0]  RST_BREAK_FLAG_CTL = 8'h00;
  localparam logic [7:0]  RST_BREAK_STATUS   = 8'h00;
  localparam logic [12:0] REC_LONG_CYC       = 13'h1000;
  localparam logic [12:0] REC_SHORT_CYC      = 13'h0020;
  localparam int          STACK_DELAY_CYC    = 1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    SSILP_RUN,
    SSILP_WAIT,
    SSILP_WAIT_EXIT,
    SSILP_STOP,
    SSILP_RECOVER
  } ssilp_state_t;

  typedef struct packed {
    logic pin;
    logic wdog;
    logic bad_opcode;
    logic bad_fetch;
    logic monitor;
    logic low_voltage;
  } ssilp_rst_src_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        rd;
    logic        wr;
    logic [7:0]  wdata;
  } ssilp_bus_t;

endpackage : ssilp_pkg

// >>> dv/ssilp_properties.sv
/* Port-level checker for ssilp_top, bound to every instance.
   Assumes the single clk_sys domain and synchronous rst_n. */
`timescale 1ns/1ns
`default_nettype none
module ssilp_checker #(
  parameter int NUM_FLAGS = 22
) (
  // Clock, reset and inputs
  input wire logic                      clk_sys,
  input wire logic                      rst_n,
  input wire logic                      por_event,
  input wire ssilp_pkg::ssilp_rst_src_t rst_src,
  input wire ssilp_pkg::ssilp_bus_t     bus_in,
  input wire logic [NUM_FLAGS:1]        irq_pending,
  input wire logic                      break_req,
  input wire logic                      wait_exec,
  input wire logic                      stop_exec,
  input wire logic                      watchdog_disable,
  input wire logic                      oscillator_in_stop_enable,
  // Block outputs
  input wire logic [7:0]                bus_rdata,
  input wire logic                      cpu_reset,
  input wire logic                      force_swi_vector,
  input wire logic                      clear_imask,
  input wire logic                      start_stacking,
  input wire logic                      cpu_clk_en,
  input wire logic                      bus_clock_double,
  input wire logic                      bus_clock_quad,
  input wire logic                      watchdog_run,
  input wire logic                      flag_clear_allow,
  input wire logic                      break_active
);
  import ssilp_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic       break_flag_clear_enable_q, break_flag_clear_enable_d, quiet, rc_rd;
  logic [6:1] pend_q;
  assign quiet = (rst_src == '0) && !por_event;
  assign rc_rd = bus_in.rd && (bus_in.addr == ADDR_RESET_CAUSE);
  always_comb begin
    break_flag_clear_enable_d = break_flag_clear_enable_q;
    if (bus_in.wr && (bus_in.addr == ADDR_BREAK_FLAG_CTL)) begin
      break_flag_clear_enable_d = bus_in.wdata[BF_BREAK_FLAG_CLEAR_ENABLE];
    end
  end
  always_ff @(posedge clk_sys) begin
    break_flag_clear_enable_q <= rst_n ? break_flag_clear_enable_d : 1'b0;
    pend_q <= irq_pending[6:1];
  end
  AST_WAIT_ENTRY: assert property (wait_exec |=> clear_imask && !cpu_clk_en && bus_clock_double)
    else $error("wait entry controls wrong");
  AST_WDOG_WAIT: assert property (wait_exec && !watchdog_disable |=> watchdog_run)
    else $error("watchdog stopped in wait");
  AST_STOP_CLOCKS: assert property (stop_exec |=> clear_imask && !bus_clock_double
    && (bus_clock_quad == $past(oscillator_in_stop_enable))) else $error("stop clocks wrong");
  AST_WAIT_STACK: assert property (!cpu_clk_en && bus_clock_double && $rose(irq_pending != '0)
    |-> ##2 start_stacking) else $error("wait wake timing wrong");
  AST_SWI_BREAK: assert property ($rose(break_req) |=> force_swi_vector)
    else $error("break did not force vector");
  AST_FLAG_PROTECT: assert property ((break_active && $stable(break_flag_clear_enable_q))[*2] |-> flag_clear_allow == break_flag_clear_enable_q)
    else $error("flag protection wrong");
  AST_RESET_TOP: assert property (!quiet |=> cpu_reset)
    else $error("reset not raised");
  AST_CAUSE_CLEAR: assert property (rc_rd && quiet ##1 quiet ##1 rc_rd && quiet |=> bus_rdata == 8'h00)
    else $error("cause not cleared by read");
  AST_PEND_LOW: assert property (bus_in.rd && (bus_in.addr == ADDR_PEND_A) |=> bus_rdata == {pend_q, 2'b00})
    else $error("pending view a wrong");
  COV_STACK: cover property (start_stacking);
  COV_SWI: cover property (force_swi_vector);
  COV_CAUSE: cover property (rc_rd ##1 bus_rdata != 8'h00);
endmodule // ssilp_checker
bind ssilp_top ssilp_checker #(.NUM_FLAGS(NUM_FLAGS)) u_checker (
  .clk_sys, .rst_n, .por_event, .rst_src, .bus_in, .irq_pending, .break_req, .wait_exec,
  .stop_exec, .watchdog_disable, .oscillator_in_stop_enable, .bus_rdata, .cpu_reset,
  .force_swi_vector, .clear_imask, .start_stacking, .cpu_clk_en, .bus_clock_double,
  .bus_clock_quad, .watchdog_run, .flag_clear_allow, .break_active
);
`default_nettype wire

// >>> dv/ssilp_periph_model.sv
/* Peripheral and break-module model facing ssilp_top.
   Commanded by the bench at falling edges; clk_sys domain only. */
`timescale 1ns/1ns
`default_nettype none
module ssilp_periph_model (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // Bench commands
  input  wire logic [22:1] set_flags,
  input  wire logic        clr_cmd,
  input  wire logic        brk_cmd,
  // Block side
  input  wire logic        flag_clear_allow,
  output var  logic [22:1] irq_pending,
  output var  logic        break_req,
  output var  logic        quad_tick
);
  logic [22:1] flags_d;
  logic        tick_d;
  always_comb begin
    flags_d = irq_pending | set_flags;
    if (clr_cmd && flag_clear_allow) begin
      flags_d = set_flags;
    end
    tick_d = !quad_tick;
  end
  always_ff @(posedge clk_sys) begin
    irq_pending <= rst_n ? flags_d : '0;
    break_req   <= rst_n && brk_cmd;
    quad_tick   <= rst_n && tick_d;
  end
endmodule // ssilp_periph_model
`default_nettype wire

// >>> dv/ssilp_top_test.sv
/* Self-checking bench for ssilp_top with the peripheral model.
   Inputs change at falling edges of a 50 MHz clk_sys. */
`timescale 1ns/1ns
`default_nettype none
module ssilp_top_test;
  import ssilp_pkg::*;
  localparam int REC = 64;
  logic           clk_sys = 1'b0, rst_n = 1'b0, por_event = 1'b0;
  ssilp_rst_src_t rst_src = '0;
  ssilp_bus_t     bus_in = '0;
  logic [22:1]    irq_pending, set_flags = '0;
  logic           clr_cmd = 1'b0, brk_cmd = 1'b0, wait_exec = 1'b0, stop_exec = 1'b0;
  logic           short_recovery_select = 1'b0, oscillator_in_stop_enable = 1'b0;
  logic [7:0]     bus_rdata;
  logic           break_req, quad_tick, cpu_reset, force_swi_vector, clear_imask, start_stacking;
  logic           cpu_clk_en, bus_clock_double, bus_clock_quad, watchdog_run, flag_clear_allow;
  logic           break_active;
  int             bad_count = 0, n_checks = 0;
  always #10 clk_sys = ~clk_sys;
  ssilp_top #(.REC_LONG(13'(REC))) uut (.clk_sys, .rst_n, .por_event, .rst_src, .bus_in,
    .bus_rdata, .irq_pending, .break_req, .emulation_mode(1'b0), .wait_exec, .stop_exec,
    .watchdog_disable(1'b0), .short_recovery_select, .oscillator_in_stop_enable, .quad_tick,
    .cpu_reset, .force_swi_vector, .clear_imask, .start_stacking, .cpu_clk_en,
    .bus_clock_double, .bus_clock_quad, .watchdog_run, .flag_clear_allow, .break_active);
  ssilp_periph_model u_periph (.clk_sys, .rst_n, .set_flags, .clr_cmd, .brk_cmd,
    .flag_clear_allow, .irq_pending, .break_req, .quad_tick);
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic acc(input logic [15:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
    bus_in = '{addr: a, rd: !w, wr: w, wdata: d};
    @(negedge clk_sys);
    q = bus_rdata;
    bus_in.rd = 1'b0;
    bus_in.wr = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] e);
    logic [7:0] q;
    acc(a, 1'b0, 8'h00, q);
    chk(what, e, q);
  endtask
  task automatic wait_hi(input string what, ref logic s, input int lim, output int n);
    for (n = 0; s !== 1'b1; n++) begin
      if (n == lim) begin
        chk(what, 1, 0);
        end_sim;
      end
      @(negedge clk_sys);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic flag(input int k);
    set_flags[k] = 1'b1;
    @(negedge clk_sys);
    set_flags = '0;
    @(negedge clk_sys);
  endtask
  task automatic src(input logic p, input ssilp_rst_src_t s);
    por_event = p;
    rst_src = s;
    @(negedge clk_sys);
    chk("cpu_reset", 1, cpu_reset);
    por_event = 1'b0;
    rst_src = '0;
    @(negedge clk_sys);
  endtask
  task automatic t_cause;
    int pos [6] = '{RC_PIN, RC_WDOG, RC_BADOP, RC_BADAD, RC_MON, RC_LVI};
    src(1'b1, '0);
    src(1'b0, 6'h20);
    rd_chk("cause accumulate", ADDR_RESET_CAUSE, 8'hC0);
    rd_chk("cause cleared", ADDR_RESET_CAUSE, 8'h00);
    for (int i = 0; i < 6; i++) begin
      src(1'b0, 6'h20 >> i);
      rd_chk("cause bit", ADDR_RESET_CAUSE, 8'h01 << pos[i]);
    end
    src(1'b0, 6'h01);
    src(1'b1, '0);
    rd_chk("power-on clears", ADDR_RESET_CAUSE, 8'h80);
    $display("test cause done");
  endtask
  task automatic t_regs;
    logic [7:0] q;
    rd_chk("status reset", ADDR_BREAK_STATUS, RST_BREAK_STATUS);
    rd_chk("control reset", ADDR_BREAK_FLAG_CTL, RST_BREAK_FLAG_CTL);
    acc(ADDR_BREAK_FLAG_CTL, 1'b1, 8'h80, q);
    rd_chk("control rw", ADDR_BREAK_FLAG_CTL, 8'h80);
    acc(16'hFE02, 1'b1, 8'hFF, q);
    rd_chk("unmapped", 16'hFE02, 8'h00);
    $display("test regs done");
  endtask
  task automatic t_pend;
    logic [22:1] pat = 22'h2AB5C3;
    set_flags = pat;
    @(negedge clk_sys);
    set_flags = '0;
    rd_chk("pending a", ADDR_PEND_A, {pat[6:1], 2'b00});
    rd_chk("pending b", ADDR_PEND_B, pat[14:7]);
    rd_chk("pending c", ADDR_PEND_C, pat[22:15]);
    pulse(clr_cmd);
    chk("cleared outside break", 0, irq_pending);
    $display("test pending done");
  endtask
  task automatic t_break;
    logic [7:0] q;
    int         n;
    acc(ADDR_BREAK_FLAG_CTL, 1'b1, 8'h00, q);
    flag(3);
    brk_cmd = 1'b1;
    wait_hi("vector", force_swi_vector, 20, n);
    repeat (2) @(negedge clk_sys);
    chk("break active", 1, break_active);
    pulse(clr_cmd);
    chk("protected", 22'h4, irq_pending);
    acc(ADDR_BREAK_FLAG_CTL, 1'b1, 8'h80, q);
    pulse(clr_cmd);
    chk("cleared in break", 0, irq_pending);
    brk_cmd = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("stays cleared", 0, irq_pending);
    $display("test break done");
  endtask
  task automatic t_wait;
    int n;
    wait_exec = 1'b1;
    @(negedge clk_sys);
    wait_exec = 1'b0;
    chk("mask cleared", 1, clear_imask);
    chk("cpu clock off", 0, cpu_clk_en);
    chk("periph clock on", 1, bus_clock_double);
    repeat (3) @(negedge clk_sys);
    chk("watchdog runs", 1, watchdog_run);
    flag(1);
    wait_hi("wait wake", start_stacking, 10, n);
    chk("wake delay", 1, n);
    pulse(clr_cmd);
    $display("test wait done");
  endtask
  task automatic t_stop;
    int n, e;
    for (int i = 0; i < 2; i++) begin
      short_recovery_select = i[0];
      oscillator_in_stop_enable = i[0];
      e = i ? 64 : 2 * REC;
      pulse(stop_exec);
      chk("double off", 0, bus_clock_double);
      chk("quad in stop", i, bus_clock_quad);
      flag(2);
      wait_hi("recovery", start_stacking, 4 * REC, n);
      chk("recovery span", 1, n >= e - 4 && n <= e + 4);
      pulse(clr_cmd);
    end
    $display("test stop done");
  endtask
  initial begin
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    t_cause;
    t_regs;
    t_pend;
    t_break;
    t_wait;
    t_stop;
    end_sim;
  end
endmodule // ssilp_top_test
`default_nettype wire
